// >>> bld_pkg.sv
// package for the backlight level, dim and off control block
// assumes a 250 MHz core clock and byte-wide register access
package bld_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_ENABLE_FLAGS = 8'h00;
    localparam logic [7:0] ADDR_CONTROL      = 8'h02;
    localparam logic [7:0] ADDR_TIMER_CFG    = 8'h03;
    localparam logic [7:0] ADDR_L1_MAX       = 8'h05;
    localparam logic [7:0] ADDR_L1_DIM       = 8'h06;
    localparam logic [7:0] ADDR_L2_MAX       = 8'h07;
    localparam logic [7:0] ADDR_L2_DIM       = 8'h08;
    localparam logic [7:0] ADDR_L3_MAX       = 8'h09;
    localparam logic [7:0] ADDR_L3_DIM       = 8'h0a;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_STANDBY_BAR = 7;
    localparam int BIT_BACKLIGHT_ENABLE_BIT       = 0;
    localparam int BIT_DIM_EN      = 1;
    localparam int POS_LEVEL_SEL   = 0;
    localparam int POS_LAW_SEL     = 4;
    localparam int BIT_KEYPAD_BL   = 6;
    localparam int POS_DIM_TIMER   = 0;
    localparam int POS_OFF_TIMER   = 4;
    // ------------------------------------------------------------
    // reset values and encodings
    // ------------------------------------------------------------
    localparam logic [7:0] RST_ENABLE_FLAGS = 8'h00;
    localparam logic [7:0] RST_CONTROL      = 8'h00;
    localparam logic [7:0] RST_TIMER_CFG    = 8'h00;
    localparam logic [7:0] RST_CODE         = 8'h00;
    localparam logic [1:0] LEVEL_BRIGHT     = 2'h0;
    localparam logic [1:0] LEVEL_MEDIUM     = 2'h1;
    localparam logic [1:0] LEVEL_LOW_LIGHT  = 2'h2;
    localparam logic [1:0] LAW_LINEAR       = 2'h0;
    localparam logic [1:0] LAW_SQUARE       = 2'h1;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ      = 250;
    localparam int TICK_MS      = 10;
    localparam int TICK_CYCLES  = TICK_MS * CLK_MHZ * 1000;
    localparam int MIN_TIMER_S  = 10;
    localparam int MAX_TIMER_S  = 120;
    localparam int TICKS_PER_S  = 1000 / TICK_MS;
endpackage

// >>> bld_law_map.sv
// code-to-sink mapping, linear or square law
// assumes the caller registers the result; pure combinational
`timescale 1ns/1ps
module bld_law_map #(
    parameter int CODE_W = 7
) (
    input  wire logic [CODE_W-1:0]   i_code,
    input  wire logic [1:0]          i_law,
    output logic      [2*CODE_W-1:0] o_sink
);
    localparam int FULL = (1 << CODE_W) - 1;
    logic [2*CODE_W-1:0] square;
    // square law scaled so code 127 still yields full scale: code^2/127
    always_comb begin
        square = (2*CODE_W)'((i_code * i_code) / FULL);
        if (i_law == bld_pkg::LAW_SQUARE) begin
            o_sink = {{CODE_W{1'b0}}, square[CODE_W-1:0]};
        end else begin
            o_sink = {{CODE_W{1'b0}}, i_code};
        end
    end
endmodule

// >>> bld_ctrl.sv
// backlight level, dim and off control with its register file
// assumes byte register port from a serial bus front end on the same clock
//
// Notes on behaviour
// - level 00 uses registers 05 max and 06 dim; default level
// - level 01 uses registers 07 max and 08 dim
// - level 10 uses registers 09 max and 0a dim
// - level select in register 02 is writable; ambient logic may set it
// - every max and dim code is seven bits, 128 levels
// - law 00 gives current linear in the code
// - law 01 gives square law current
// - in operating mode, enable bit turns backlight on or off
// - dim bit selects dim code while on; clearing returns to max
// - dim code above max is allowed; software should avoid it
// - in keypad mode, a key press with keypad bit set sets the enable bit
// - dim timer field in register 03 with fifteen durations
// - enable starts dim timer at max; expiry sets dim bit
// - clearing dim or rewriting enable restarts dim timer
// - rewriting enable reloads dim timer; clearing enable turns off
// - off timer field in register 03 with fifteen durations
// - enable starts off timer; expiry clears enable bit
// - rewriting enable reloads off timer; clearing turns off at once
// - both timers: max, then dim, then off
`timescale 1ns/1ps
module bld_ctrl #(
    parameter int CODE_W      = 7,
    parameter int TICK_CYCLES = bld_pkg::TICK_CYCLES
) (
    input  wire logic                i_core_clk,
    input  wire logic                i_rstn,
    input  wire logic [7:0]          i_reg_addr,
    input  wire logic [7:0]          i_reg_wdata,
    input  wire logic                i_reg_wr,
    input  wire logic                i_reg_rd,
    input  wire logic                i_keypad_mode,
    input  wire logic                i_key_press,
    input  wire logic                i_auto_level_valid,
    input  wire logic [1:0]          i_auto_level,
    output logic      [7:0]          o_reg_rdata,
    output logic                     o_sink_on,
    output logic      [2*CODE_W-1:0] o_sink_level
);
    // the read path packs a code and a zero into one byte, so only seven bits fit
    if (CODE_W != 7) begin
        $error("code width must be seven");
    end
    if (TICK_CYCLES < 1) begin
        $error("tick must be at least one cycle");
    end

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    logic [7:0]        enable_flags;
    logic [7:0]        control;
    logic [7:0]        timer_cfg;
    logic [CODE_W-1:0] max_code [3];
    logic [CODE_W-1:0] dim_code [3];

    logic [1:0] level_select;
    logic [1:0] law_select;
    logic       keypad_backlight_bit;
    logic       backlight_enable_bit;
    logic       dim_en;
    logic       standby_bar;
    logic [3:0] dim_timer_field;
    logic [3:0] off_timer_field;

    assign level_select         = control[bld_pkg::POS_LEVEL_SEL +: 2];
    assign law_select           = control[bld_pkg::POS_LAW_SEL +: 2];
    assign keypad_backlight_bit = control[bld_pkg::BIT_KEYPAD_BL];
    assign backlight_enable_bit = enable_flags[bld_pkg::BIT_BACKLIGHT_ENABLE_BIT];
    assign dim_en               = enable_flags[bld_pkg::BIT_DIM_EN];
    assign standby_bar          = enable_flags[bld_pkg::BIT_STANDBY_BAR];
    assign dim_timer_field      = timer_cfg[bld_pkg::POS_DIM_TIMER +: 4];
    assign off_timer_field      = timer_cfg[bld_pkg::POS_OFF_TIMER +: 4];

    // ------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------
    // write strobe aimed at one register offset
    function automatic logic wr_hit(input logic       wr,
                                    input logic [7:0] a,
                                    input logic [7:0] target);
        wr_hit = wr && (a == target);
    endfunction

    logic wr_enable_reg;
    logic key_on;
    logic enable_set_req;
    logic dim_expire;
    logic off_expire;

    assign wr_enable_reg  = wr_hit(i_reg_wr, i_reg_addr, bld_pkg::ADDR_ENABLE_FLAGS);
    assign key_on         = i_keypad_mode && keypad_backlight_bit && i_key_press;
    // any write of a one to the enable bit counts as a fresh start
    assign enable_set_req = key_on
                         || (wr_enable_reg && i_reg_wdata[bld_pkg::BIT_BACKLIGHT_ENABLE_BIT]);

    // level index from the select field; 11 falls back to the bright level
    function automatic logic [1:0] level_index(input logic [1:0] sel);
        unique case (sel)
            bld_pkg::LEVEL_MEDIUM:    level_index = 2'h1;
            bld_pkg::LEVEL_LOW_LIGHT: level_index = 2'h2;
            default:                  level_index = 2'h0;
        endcase
    endfunction

    function automatic logic code_addr(input logic [7:0] a);
        code_addr = (a >= bld_pkg::ADDR_L1_MAX) && (a <= bld_pkg::ADDR_L3_DIM);
    endfunction

    // ------------------------------------------------------------
    // enable and dim flags
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            enable_flags <= bld_pkg::RST_ENABLE_FLAGS;
        end else begin
            if (wr_enable_reg) begin
                enable_flags <= i_reg_wdata;
            end
            // a fresh enable in the expiry cycle restarts at max, so it beats the dim set
            if (dim_expire && !enable_set_req) begin
                enable_flags[bld_pkg::BIT_DIM_EN] <= 1'b1;
            end
            if (off_expire) begin
                enable_flags[bld_pkg::BIT_BACKLIGHT_ENABLE_BIT] <= 1'b0;
            end
            // an enable request arriving with expiry wins
            if (key_on) begin
                enable_flags[bld_pkg::BIT_BACKLIGHT_ENABLE_BIT] <= 1'b1;
            end
            if (enable_set_req) begin
                enable_flags[bld_pkg::BIT_BACKLIGHT_ENABLE_BIT] <= 1'b1;
            end
            // a key-press enable with no enable write in that cycle comes up at max with the timers restarted
            if (enable_set_req && !wr_enable_reg) begin
                enable_flags[bld_pkg::BIT_DIM_EN] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // other control registers
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            control   <= bld_pkg::RST_CONTROL;
            timer_cfg <= bld_pkg::RST_TIMER_CFG;
        end else begin
            if (wr_hit(i_reg_wr, i_reg_addr, bld_pkg::ADDR_CONTROL)) begin
                control <= i_reg_wdata;
            end else if (i_auto_level_valid) begin
                control[bld_pkg::POS_LEVEL_SEL +: 2] <= i_auto_level;
            end
            if (wr_hit(i_reg_wr, i_reg_addr, bld_pkg::ADDR_TIMER_CFG)) begin
                timer_cfg <= i_reg_wdata;
            end
        end
    end

    // dim above max is stored as written, nothing clamps it
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int i = 0; i < 3; i++) begin
                max_code[i] <= bld_pkg::RST_CODE[CODE_W-1:0];
                dim_code[i] <= bld_pkg::RST_CODE[CODE_W-1:0];
            end
        end else if (i_reg_wr && code_addr(i_reg_addr)) begin
            for (int i = 0; i < 3; i++) begin
                if (i_reg_addr == bld_pkg::ADDR_L1_MAX + 8'(2*i)) begin
                    max_code[i] <= i_reg_wdata[CODE_W-1:0];
                end
                if (i_reg_addr == bld_pkg::ADDR_L1_DIM + 8'(2*i)) begin
                    dim_code[i] <= i_reg_wdata[CODE_W-1:0];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // timebase and timers
    // ------------------------------------------------------------
    localparam int TB_W = $clog2(TICK_CYCLES + 1);
    localparam int T_W  = 16;
    // the longest duration in ticks must fit the countdown registers
    if (bld_pkg::MAX_TIMER_S * bld_pkg::TICKS_PER_S >= (1 << T_W)) begin
        $error("timer counter too narrow");
    end
    logic [TB_W-1:0] tb_cnt;
    logic            tick;

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tb_cnt <= '0;
            tick   <= 1'b0;
        end else begin
            tick <= (tb_cnt == TB_W'(TICK_CYCLES - 1));
            if (tb_cnt == TB_W'(TICK_CYCLES - 1)) begin
                tb_cnt <= '0;
            end else begin
                tb_cnt <= tb_cnt + 1'b1;
            end
        end
    end

    // code n spans 10 s at code 1 to 120 s at code 15, step near 7.86 s
    function automatic logic [T_W-1:0] timer_ticks(input logic [3:0] f);
        int s;
        s = bld_pkg::MIN_TIMER_S
          + ((int'(f) - 1) * (bld_pkg::MAX_TIMER_S - bld_pkg::MIN_TIMER_S)) / 14;
        timer_ticks = T_W'(s * bld_pkg::TICKS_PER_S);
    endfunction

    logic [T_W-1:0] dim_cnt;
    logic [T_W-1:0] off_cnt;
    logic           dim_run;
    logic           off_run;
    logic           dim_clear_wr;
    logic           lit;

    assign lit          = standby_bar && backlight_enable_bit;
    assign dim_clear_wr = wr_enable_reg && !i_reg_wdata[bld_pkg::BIT_DIM_EN] && dim_en;
    assign dim_expire   = dim_run && tick && (dim_cnt == 16'h0001);
    assign off_expire   = off_run && tick && (off_cnt == 16'h0001);

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            dim_cnt <= '0;
            dim_run <= 1'b0;
        end else if (enable_set_req || dim_clear_wr) begin
            dim_cnt <= timer_ticks(dim_timer_field);
            dim_run <= (dim_timer_field != 4'h0);
        end else if (!lit || dim_expire) begin
            dim_run <= 1'b0;
        end else if (dim_run && tick) begin
            dim_cnt <= dim_cnt - 1'b1;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            off_cnt <= '0;
            off_run <= 1'b0;
        end else if (enable_set_req) begin
            off_cnt <= timer_ticks(off_timer_field);
            off_run <= (off_timer_field != 4'h0);
        end else if (!lit || off_expire) begin
            off_run <= 1'b0;
        end else if (off_run && tick) begin
            off_cnt <= off_cnt - 1'b1;
        end
    end

    // ------------------------------------------------------------
    // sink output
    // ------------------------------------------------------------
    logic [1:0]          lvl;
    logic [CODE_W-1:0]   active_code;
    logic [2*CODE_W-1:0] mapped;

    assign lvl         = level_index(level_select);
    assign active_code = dim_en ? dim_code[lvl] : max_code[lvl];

    bld_law_map #(
        .CODE_W (CODE_W)
    ) u_law (
        .i_code (active_code),
        .i_law  (law_select),
        .o_sink (mapped)
    );

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_sink_on    <= 1'b0;
            o_sink_level <= '0;
        end else begin
            o_sink_on    <= lit;
            o_sink_level <= lit ? mapped : '0;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // registered so the byte stands until the next read strobe
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            unique case (i_reg_addr)
                bld_pkg::ADDR_ENABLE_FLAGS: o_reg_rdata <= enable_flags;
                bld_pkg::ADDR_CONTROL:      o_reg_rdata <= control;
                bld_pkg::ADDR_TIMER_CFG:    o_reg_rdata <= timer_cfg;
                bld_pkg::ADDR_L1_MAX:       o_reg_rdata <= {1'b0, max_code[0]};
                bld_pkg::ADDR_L1_DIM:       o_reg_rdata <= {1'b0, dim_code[0]};
                bld_pkg::ADDR_L2_MAX:       o_reg_rdata <= {1'b0, max_code[1]};
                bld_pkg::ADDR_L2_DIM:       o_reg_rdata <= {1'b0, dim_code[1]};
                bld_pkg::ADDR_L3_MAX:       o_reg_rdata <= {1'b0, max_code[2]};
                bld_pkg::ADDR_L3_DIM:       o_reg_rdata <= {1'b0, dim_code[2]};
                default:                    o_reg_rdata <= 8'h00;
            endcase
        end
    end
endmodule

// >>> bld_ctrl_assertions.sv
// checker for the backlight control block, sees only its top ports
// assumes the bind below; reset is asynchronous and active low
`timescale 1ns/1ps
module bld_ctrl_assertions (
    input wire logic        i_core_clk,
    input wire logic        i_rstn,
    input wire logic [7:0]  i_reg_addr,
    input wire logic [7:0]  i_reg_wdata,
    input wire logic        i_reg_wr,
    input wire logic        i_reg_rd,
    input wire logic        i_keypad_mode,
    input wire logic        i_key_press,
    input wire logic [7:0]  o_reg_rdata,
    input wire logic        o_sink_on,
    input wire logic [13:0] o_sink_level
);
    // shadows of software-only bits; ambient updates never touch them
    logic kp_en;
    logic stby;
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            kp_en <= 1'b0;
            stby  <= 1'b0;
        end else if (i_reg_wr) begin
            if (i_reg_addr == 8'h02) kp_en <= i_reg_wdata[6];
            if (i_reg_addr == 8'h00) stby <= i_reg_wdata[7];
        end
    end
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);
    a_off_level_zero: assert property (!o_sink_on |-> o_sink_level == 14'h0)
        else $error("sink level nonzero while dark");
    a_level_in_range: assert property (o_sink_level <= 14'h7f)
        else $error("sink level above full scale");
    a_rd_unmapped: assert property (i_reg_rd && (i_reg_addr == 8'h01
        || i_reg_addr == 8'h04 || i_reg_addr > 8'h0a) |=> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_code_bit7_zero: assert property (i_reg_rd && i_reg_addr >= 8'h05
        && i_reg_addr <= 8'h0a |=> !o_reg_rdata[7])
        else $error("code register top bit set");
    a_rdata_holds: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
        else $error("read data changed without read");
    a_enable_on: assert property (i_reg_wr && i_reg_addr == 8'h00
        && i_reg_wdata[7] && i_reg_wdata[0] |-> ##2 o_sink_on)
        else $error("enable write did not light");
    a_disable_off: assert property (i_reg_wr && i_reg_addr == 8'h00 && !i_key_press
        && !(i_reg_wdata[7] && i_reg_wdata[0]) |-> ##2 !o_sink_on)
        else $error("disable write left sink lit");
    a_key_wakes: assert property (i_key_press && i_keypad_mode && kp_en && stby
        && !i_reg_wr |-> ##2 o_sink_on)
        else $error("key press did not light");
    a_standby_dark: assert property (!stby |-> ##1 !o_sink_on)
        else $error("sink lit in standby");
    cover property ($rose(o_sink_on));
    cover property (i_key_press && i_keypad_mode && kp_en);
    cover property ($fell(o_sink_on) && !$past(i_reg_wr, 2));
endmodule
bind bld_ctrl bld_ctrl_assertions i_chk (.i_core_clk, .i_rstn, .i_reg_addr,
    .i_reg_wdata, .i_reg_wr, .i_reg_rd, .i_keypad_mode, .i_key_press,
    .o_reg_rdata, .o_sink_on, .o_sink_level);

// >>> bld_host_model.sv
// host software model driving the byte register port
// assumes requests are taken at the rising edge; drives at falling edge
`timescale 1ns/1ps
module bld_host_model (
    input  wire logic       i_core_clk,
    output logic      [7:0] o_addr,
    output logic      [7:0] o_wdata,
    output logic            o_wr,
    output logic            o_rd
);
    initial begin
        o_addr  = 8'h00;
        o_wdata = 8'h00;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
    end
    // one strobe cycle; the bus is scrambled after so stale values never pass
    task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(negedge i_core_clk);
        o_addr  = a;
        o_wdata = d;
        o_wr    = w;
        o_rd    = !w;
        @(negedge i_core_clk);
        o_wr    = 1'b0;
        o_rd    = 1'b0;
        o_addr  = ~a;
        o_wdata = ~d;
    endtask
endmodule

// >>> tb_top.sv
// self-checking bench for the backlight control block
// assumes the host model drives registers and the checker is bound
`timescale 1ns/1ps
module tb_top;
    localparam int TICK = 2;
    localparam int CPS  = TICK * bld_pkg::TICKS_PER_S;
    logic        clk;
    logic        rstn;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic        kp_mode;
    logic        key;
    logic        alv;
    logic [1:0]  al;
    logic [7:0]  rdata;
    logic        sink_on;
    logic [13:0] sink;
    logic [6:0]  code [6];
    logic [15:0] q [$];
    logic        rd_d;
    logic        rd_dd;
    int          n_mismatch;
    int          comparisons;
    bld_host_model i_host (.i_core_clk(clk), .o_addr(addr), .o_wdata(wdata),
        .o_wr(wr), .o_rd(rd));
    bld_ctrl #(.TICK_CYCLES(TICK)) i_dut (.i_core_clk(clk), .i_rstn(rstn),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_keypad_mode(kp_mode), .i_key_press(key), .i_auto_level_valid(alv),
        .i_auto_level(al), .o_reg_rdata(rdata), .o_sink_on(sink_on),
        .o_sink_level(sink));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic [13:0] seen, input logic [13:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [13:0] law(input logic [6:0] c, input logic [1:0] lw);
        law = (lw == 2'h1) ? {7'h0, c} * {7'h0, c} / 14'h7f : {7'h0, c};
    endfunction
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        i_host.access(a, d, 1'b1);
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        q.push_back({m, e & m});
        i_host.access(a, 8'h00, 1'b0);
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic press();
        @(negedge clk);
        key = 1'b1;
        @(negedge clk);
        key = 1'b0;
        wait_n(2);
    endtask
    task automatic results();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // read results are matched against the oldest note
    always @(posedge clk) begin
        rd_d  <= rd;
        rd_dd <= rd_d;
    end
    always @(negedge clk) begin
        logic [15:0] m;
        if (rd_dd === 1'b1) begin
            m = q.pop_front();
            check(14'(rdata & m[15:8]), 14'(m[7:0]));
        end
    end
    initial begin
        #240000;
        n_mismatch++;
        results();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        int j;
        {rstn, kp_mode, key, alv, al} = '0;
        n_mismatch  = 0;
        comparisons = 0;
        void'($urandom(57513));
        wait_n(5);
        rstn = 1'b1;
        for (int a = 0; a < 12; a++) rd_reg(8'(a), 8'h00, 8'hff);
        check(14'(sink_on), 14'h0);
        for (int i = 0; i < 6; i++) begin
            code[i] = 7'($urandom);
            wr_reg(8'h05 + 8'(i), {1'b1, code[i]});
            rd_reg(8'h05 + 8'(i), {1'b0, code[i]}, 8'hff);
        end
        for (int lv = 0; lv < 4; lv++) begin
            for (int lw = 0; lw < 4; lw++) begin
                j = (lv == 3) ? 0 : lv;
                wr_reg(8'h02, {2'h0, 2'(lw), 2'h0, 2'(lv)});
                wr_reg(8'h00, 8'h81);
                wait_n(2);
                check(sink, law(code[2*j], 2'(lw)));
                wr_reg(8'h00, 8'h83);
                wait_n(2);
                check(sink, law(code[2*j+1], 2'(lw)));
                rd_reg(8'h02, {2'h0, 2'(lw), 2'h0, 2'(lv)}, 8'h73);
            end
        end
        wr_reg(8'h00, 8'h01);
        wait_n(2);
        check(14'(sink_on), 14'h0);
        wr_reg(8'h02, 8'h40);
        press();
        check(14'(sink_on), 14'h0);
        kp_mode = 1'b1;
        wr_reg(8'h00, 8'h80);
        press();
        check(sink, law(code[0], 2'h0));
        rd_reg(8'h00, 8'h81, 8'h83);
        @(negedge clk);
        alv = 1'b1;
        al  = 2'h2;
        @(negedge clk);
        alv = 1'b0;
        rd_reg(8'h02, 8'h42, 8'h73);
        check(sink, law(code[4], 2'h0));
        // timers are set before enabling, as software must
        wr_reg(8'h00, 8'h80);
        wr_reg(8'h03, 8'h21);
        wr_reg(8'h00, 8'h81);
        wait_n(10 * CPS - 20);
        check(sink, law(code[4], 2'h0));
        wait_n(40);
        check(sink, law(code[5], 2'h0));
        rd_reg(8'h00, 8'h83, 8'h83);
        wait_n(7 * CPS - 50);
        check(14'(sink_on), 14'h1);
        wait_n(50);
        check(14'(sink_on), 14'h0);
        // off expiry clears only the enable bit; the dim bit set before stays
        rd_reg(8'h00, 8'h82, 8'h83);
        wr_reg(8'h00, 8'h81);
        wait_n(5 * CPS);
        wr_reg(8'h00, 8'h81);
        wait_n(5 * CPS + 500);
        check(sink, law(code[4], 2'h0));
        wait_n(5 * CPS - 520);
        check(sink, law(code[4], 2'h0));
        wait_n(40);
        check(sink, law(code[5], 2'h0));
        wr_reg(8'h00, 8'h81);
        wait_n(2);
        check(sink, law(code[4], 2'h0));
        wr_reg(8'h03, 8'h0f);
        wr_reg(8'h00, 8'h81);
        wait_n(120 * CPS - 20);
        check(sink, law(code[4], 2'h0));
        wait_n(40);
        check(sink, law(code[5], 2'h0));
        wait_n(1000);
        check(14'(sink_on), 14'h1);
        wait_n(4);
        results();
    end
endmodule
